// ### src/lcse_cfg.svh
// register offsets, field positions, reset values and pattern codes
// assumes inclusion by bare name from the status/event register module
`ifndef LCSE_CFG_SVH
`define LCSE_CFG_SVH

`define LCSE_ADDR_LOOP_EVT    8'hac
`define LCSE_ADDR_PLL         8'had
`define LCSE_ADDR_CLK_EVT     8'hd8
`define LCSE_ADDR_PATTERN     8'hda
`define LCSE_ADDR_MODE        8'he7
`define LCSE_ADDR_CLK_LOSS    8'hfe
`define LCSE_ADDR_GLOBAL_PTR  8'h6e
`define LCSE_ADDR_CHAN_PTR    8'h6f
`define LCSE_ADDR_CLK_MASK    8'hd9

`define LCSE_BIT_SYS_UP       3
`define LCSE_BIT_SYS_DOWN     2
`define LCSE_BIT_LINE_UP      1
`define LCSE_BIT_LINE_DOWN    0
`define LCSE_BIT_PLL_LOCKED   1
`define LCSE_BIT_PLL_CHANGED  0
`define LCSE_BIT_REF_SWITCH   4
`define LCSE_BIT_SRC_SWITCH   3
`define LCSE_BIT_TX_LOST      4
`define LCSE_BIT_ALT_LOST     3
`define LCSE_BIT_GLOBAL_LOOP  6
`define LCSE_BIT_GLOBAL_CLK   7
`define LCSE_BIT_CHAN_PLL     7

`define LCSE_PAT_NONE         3'h0
`define LCSE_PAT_PRBS         3'h2
`define LCSE_PAT_PRBS_INV     3'h3
`define LCSE_PAT_ZEROS        3'h6
`define LCSE_PAT_ONES         3'h7

`define LCSE_RUN_ORD11        5'h0c
`define LCSE_RUN_ORD15        5'h10
`define LCSE_RUN_ORD20        5'h15
`define LCSE_RUN_ORD23        5'h18

`define LCSE_RESET_BYTE       8'h00
`define LCSE_RESET_MASK       8'hff
`define LCSE_RESET_BEC        16'h0000

`endif

// ### src/lcse_pkg.sv
// types of the channel status and event register bank
// assumes the cfg header supplies all numeric constants
package lcse_pkg;

    // selected pseudo-random polynomial order
    typedef enum logic [1:0] {
        lcse_ord11,
        lcse_ord15,
        lcse_ord20,
        lcse_ord23
    } lcse_poly_t;

    // whole register state of the bank
    typedef struct packed {
        logic [3:0]  loop_evt;
        logic        pll_sync1;
        logic        pll_locked;
        logic        pll_locked_d;
        logic        pll_lock_changed;
        logic [1:0]  clk_evt;
        logic [7:0]  clk_mask;
        logic [1:0]  tx_lost_sync1;
        logic        tx_clock_lost;
        logic        alt_ref_clock_lost;
        logic        sys_loop_on;
        logic        line_loop_on;
        logic [4:0]  zero_run;
        logic [4:0]  one_run;
        logic [2:0]  pattern_state;
        logic        loopback_pattern_change_evt;
        logic [15:0] bit_error_counter;
        logic [7:0]  rd_data;
    } lcse_state_t;

endpackage : lcse_pkg

// ### src/lcse_regs.sv
// per-channel status and event registers of the line interface
// assumes detectors deliver same-clock one-cycle pulses; pll lock and
// clock-loss levels come from other clock domains and are synchronised
//
// Contract
// - system loop-up code sets bit 3, closes payload loop if auto-enabled
// - system loop-down code sets bit 2, opens payload loop if auto-enabled
// - line loop-up code sets bit 1, switches line loop on if enabled
// - line loop-down code sets bit 0, switches line loop off if enabled
// - pll locked level at bit 1 of pll status, plain read-only
// - lock level valid in both modes; generic mode reuses channel bit 7
// - lock-change flag bit 0 set on lock change, cleared on read
// - reading clock-switch event register clears all its bits
// - masked clock-switch events still flag when visible, no interrupt
// - reference switch between tx clock and alternate ref sets bit 4
// - tx clock source auto move either way sets bit 3
// - both clock-switch flags held zero when auto switching disabled
// - tx clock loss at clock status bit 4 always reported
// - alternate ref clock loss at clock status bit 3
// - pattern state bits 2:0: none 000, prbs 010, inverted 011
// - all-zero stream 110, all-ones stream 111
// - zero/one run length 12,16,21,24 for orders 11,15,20,23
// - pattern state change sets change event when pattern irq mode on
// - alarm simulation forces pattern state to none
// - no errored-pattern state; each prbs bit error bumps counter, saturating at ffff
// - mode status bit 0: 1 generic, 0 legacy compatibility
// - global pointer bits 6/7 show pending unmasked loop/clock events
// - generic mode puts pll lock at channel pointer bit 7
`timescale 1ns/1ps
`include "lcse_cfg.svh"

module lcse_regs (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_rd,
    input  wire logic              reg_wr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic              sys_loop_up_code,
    input  wire logic              sys_loop_down_code,
    input  wire logic              line_loop_up_code,
    input  wire logic              line_loop_down_code,
    input  wire logic              sys_auto_loop_en,
    input  wire logic              line_auto_loop_en,
    output logic                   payload_loop_on,
    output logic                   line_loop_on,
    input  wire logic              pll_lock_async,
    input  wire logic              legacy_mode_disable,
    input  wire logic              masked_event_visible,
    input  wire logic              auto_clock_switch_en,
    input  wire logic              ref_switch_pulse,
    input  wire logic              src_switch_pulse,
    input  wire logic              tx_clock_lost_async,
    input  wire logic              alt_ref_clock_lost_async,
    input  wire logic              pattern_irq_mode,
    input  wire logic              alarm_sim,
    input  wire lcse_pkg::lcse_poly_t poly_order,
    input  wire logic              rx_bit_valid,
    input  wire logic              rx_bit,
    input  wire logic              prbs_sync,
    input  wire logic              prbs_inverted,
    input  wire logic              prbs_bit_error,
    output logic                   loopback_pattern_change_evt,
    output logic      [15:0]       bit_error_counter,
    output logic      [7:0]        global_irq_pointer,
    output logic                   loop_event_pending,
    output logic                   clock_event_pending
);

    lcse_pkg::lcse_state_t st_ff;
    lcse_pkg::lcse_state_t nxt_st;

    logic       rd_loop;
    logic       rd_pll;
    logic       rd_clk;
    logic       rd_lbpc;
    logic [7:0] loop_byte;
    logic [7:0] pll_byte;
    logic [7:0] clk_byte;
    logic [7:0] clk_unmasked;
    logic [7:0] chan_ptr;
    logic [4:0] run_len;
    logic [2:0] pat_raw;
    logic [3:0] loop_set;
    logic [1:0] clk_set;

    // read strobes for clear-on-read registers
    assign rd_loop = reg_rd && (reg_addr == `LCSE_ADDR_LOOP_EVT);
    assign rd_pll  = reg_rd && (reg_addr == `LCSE_ADDR_PLL);
    assign rd_clk  = reg_rd && (reg_addr == `LCSE_ADDR_CLK_EVT);
    // the change event is read through the global pointer address here
    assign rd_lbpc = reg_rd && (reg_addr == `LCSE_ADDR_GLOBAL_PTR);

    // byte views of the event and status registers
    assign loop_byte = {4'h0, st_ff.loop_evt};
    assign pll_byte  = {6'h00, st_ff.pll_locked, st_ff.pll_lock_changed};
    assign clk_byte  = {3'h0, st_ff.clk_evt, 3'h0};
    assign clk_unmasked = clk_byte & ~st_ff.clk_mask;

    // incoming loop code pulses in bit order
    assign loop_set = {sys_loop_up_code, sys_loop_down_code,
                       line_loop_up_code, line_loop_down_code};
    // masked events recorded only while visibility is on
    assign clk_set = auto_clock_switch_en
                   ? ({ref_switch_pulse, src_switch_pulse}
                      & (masked_event_visible ? 2'h3 : ~st_ff.clk_mask[4:3]))
                   : 2'h0;

    always_comb begin
        unique case (poly_order)
            lcse_pkg::lcse_ord11: run_len = `LCSE_RUN_ORD11;
            lcse_pkg::lcse_ord15: run_len = `LCSE_RUN_ORD15;
            lcse_pkg::lcse_ord20: run_len = `LCSE_RUN_ORD20;
            lcse_pkg::lcse_ord23: run_len = `LCSE_RUN_ORD23;
        endcase
    end

    // pattern classification; runs win over prbs sync
    always_comb begin
        if (alarm_sim) begin
            pat_raw = `LCSE_PAT_NONE;
        end else if (st_ff.zero_run >= run_len) begin
            pat_raw = `LCSE_PAT_ZEROS;
        end else if (st_ff.one_run >= run_len) begin
            pat_raw = `LCSE_PAT_ONES;
        end else if (prbs_sync) begin
            pat_raw = prbs_inverted ? `LCSE_PAT_PRBS_INV : `LCSE_PAT_PRBS;
        end else begin
            pat_raw = `LCSE_PAT_NONE;
        end
    end

    // generic mode turns bit 7 into the pll lock level; legacy mode reads it zero
    assign chan_ptr = {legacy_mode_disable ? st_ff.pll_locked : 1'b0, 7'h00};

    // next-state for the whole bank
    always_comb begin
        nxt_st = st_ff;

        // loop events cleared on read, set wins
        nxt_st.loop_evt = (rd_loop ? 4'h0 : st_ff.loop_evt) | loop_set;

        if (sys_auto_loop_en && sys_loop_up_code) begin
            nxt_st.sys_loop_on = 1'b1;
        end else if (sys_auto_loop_en && sys_loop_down_code) begin
            nxt_st.sys_loop_on = 1'b0;
        end
        if (line_auto_loop_en && line_loop_up_code) begin
            nxt_st.line_loop_on = 1'b1;
        end else if (line_auto_loop_en && line_loop_down_code) begin
            nxt_st.line_loop_on = 1'b0;
        end

        nxt_st.pll_sync1  = pll_lock_async;
        nxt_st.pll_locked = st_ff.pll_sync1;
        // delayed copy, so only the second stage feeds logic
        nxt_st.pll_locked_d = st_ff.pll_locked;
        // change flag, set beats read clear
        nxt_st.pll_lock_changed = (rd_pll ? 1'b0 : st_ff.pll_lock_changed)
                                | (st_ff.pll_locked != st_ff.pll_locked_d);

        if (!auto_clock_switch_en) begin
            nxt_st.clk_evt = 2'h0;
        end else begin
            nxt_st.clk_evt = (rd_clk ? 2'h0 : st_ff.clk_evt) | clk_set;
        end
        if (reg_wr && (reg_addr == `LCSE_ADDR_CLK_MASK)) begin
            nxt_st.clk_mask = reg_wdata;
        end

        nxt_st.tx_lost_sync1      = {tx_clock_lost_async, alt_ref_clock_lost_async};
        nxt_st.tx_clock_lost      = st_ff.tx_lost_sync1[1];
        nxt_st.alt_ref_clock_lost = st_ff.tx_lost_sync1[0];

        if (rx_bit_valid) begin
            if (rx_bit) begin
                nxt_st.zero_run = 5'h00;
                nxt_st.one_run  = (st_ff.one_run == 5'h1f) ? st_ff.one_run
                                : st_ff.one_run + 5'h01;
            end else begin
                nxt_st.one_run  = 5'h00;
                nxt_st.zero_run = (st_ff.zero_run == 5'h1f) ? st_ff.zero_run
                                : st_ff.zero_run + 5'h01;
            end
        end
        nxt_st.pattern_state = pat_raw;

        nxt_st.loopback_pattern_change_evt = (rd_lbpc ? 1'b0
                                           : st_ff.loopback_pattern_change_evt)
                                           | (pattern_irq_mode
                                           && (pat_raw != st_ff.pattern_state));

        // counter bumps per bit error, saturating
        if (prbs_bit_error && (st_ff.bit_error_counter != 16'hffff)) begin
            nxt_st.bit_error_counter = st_ff.bit_error_counter + 16'h0001;
        end

        // registered read data; reserved bits read zero
        unique case (reg_addr)
            `LCSE_ADDR_LOOP_EVT:   nxt_st.rd_data = loop_byte;
            `LCSE_ADDR_PLL:        nxt_st.rd_data = pll_byte;
            `LCSE_ADDR_CLK_EVT:    nxt_st.rd_data = clk_byte;
            `LCSE_ADDR_CLK_MASK:   nxt_st.rd_data = st_ff.clk_mask;
            `LCSE_ADDR_PATTERN:    nxt_st.rd_data = {5'h00, st_ff.pattern_state};
            `LCSE_ADDR_MODE:       nxt_st.rd_data = {7'h00, legacy_mode_disable};
            `LCSE_ADDR_CLK_LOSS:   nxt_st.rd_data = {3'h0, st_ff.tx_clock_lost,
                                                     st_ff.alt_ref_clock_lost, 3'h0};
            `LCSE_ADDR_GLOBAL_PTR: nxt_st.rd_data = global_irq_pointer;
            `LCSE_ADDR_CHAN_PTR:   nxt_st.rd_data = chan_ptr;
            default:               nxt_st.rd_data = `LCSE_RESET_BYTE;
        endcase
        if (!reg_rd) begin
            nxt_st.rd_data = st_ff.rd_data;
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.clk_mask <= `LCSE_RESET_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign loop_event_pending  = |st_ff.loop_evt;
    assign clock_event_pending = |clk_unmasked;
    assign global_irq_pointer  = {clock_event_pending, loop_event_pending,
                                  4'h0, st_ff.loopback_pattern_change_evt, 1'b0};

    // outputs
    assign reg_rdata                   = st_ff.rd_data;
    assign payload_loop_on             = st_ff.sys_loop_on;
    assign line_loop_on                = st_ff.line_loop_on;
    assign loopback_pattern_change_evt = st_ff.loopback_pattern_change_evt;
    assign bit_error_counter           = st_ff.bit_error_counter;

endmodule : lcse_regs

// ### verification/lcse_regs_checker.sv
// assertions on the ports of the channel status/event bank
// assumes one ref_clk domain and the async active-low reset_n
`timescale 1ns/1ps
`include "lcse_cfg.svh"
module lcse_regs_checker (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic        sys_loop_up_code,
    input wire logic        sys_loop_down_code,
    input wire logic        line_loop_up_code,
    input wire logic        line_loop_down_code,
    input wire logic        sys_auto_loop_en,
    input wire logic        line_auto_loop_en,
    input wire logic        payload_loop_on,
    input wire logic        line_loop_on,
    input wire logic        auto_clock_switch_en,
    input wire logic        prbs_sync,
    input wire logic        prbs_bit_error,
    input wire logic [15:0] bit_error_counter,
    input wire logic [7:0]  global_irq_pointer,
    input wire logic        loop_event_pending,
    input wire logic        clock_event_pending
);
    // one domain, so one clocking and one reset serve all
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // a new code in the read cycle survives the clear, so leave it out
    wire any_code = sys_loop_up_code | sys_loop_down_code | line_loop_up_code;
    wire rd_loop  = reg_rd & (reg_addr == `LCSE_ADDR_LOOP_EVT) & !any_code & !line_loop_down_code;
    wire bump     = prbs_bit_error & prbs_sync & (bit_error_counter != 16'hffff);
    property p_sys_up; sys_loop_up_code && sys_auto_loop_en |=> payload_loop_on; endproperty
    a_sys_up: assert property (p_sys_up) else $error("payload loop not closed");
    property p_line_dn; line_loop_down_code && line_auto_loop_en |=> !line_loop_on; endproperty
    a_line_dn: assert property (p_line_dn) else $error("line loop not opened");
    property p_loop_flag; sys_loop_up_code |=> loop_event_pending; endproperty
    a_loop_flag: assert property (p_loop_flag) else $error("loop event not flagged");
    property p_loop_clr; rd_loop |=> !loop_event_pending; endproperty
    a_loop_clr: assert property (p_loop_clr) else $error("loop flags kept after read");
    property p_loop_ptr; global_irq_pointer[6] == loop_event_pending; endproperty
    a_loop_ptr: assert property (p_loop_ptr) else $error("loop pointer wrong");
    property p_clk_ptr; global_irq_pointer[7] == clock_event_pending; endproperty
    a_clk_ptr: assert property (p_clk_ptr) else $error("clock pointer wrong");
    property p_clk_en; $rose(clock_event_pending) |-> $past(auto_clock_switch_en); endproperty
    a_clk_en: assert property (p_clk_en) else $error("clock event while disabled");
    property p_bec; bump |=> bit_error_counter == $past(bit_error_counter) + 16'h0001; endproperty
    a_bec: assert property (p_bec) else $error("bit error not counted");
endmodule : lcse_regs_checker

bind lcse_regs lcse_regs_checker u_chk (
    .ref_clk, .reset_n, .reg_addr, .reg_rd, .sys_loop_up_code, .sys_loop_down_code,
    .line_loop_up_code, .line_loop_down_code, .sys_auto_loop_en, .line_auto_loop_en,
    .payload_loop_on, .line_loop_on, .auto_clock_switch_en, .prbs_sync, .prbs_bit_error,
    .bit_error_counter, .global_irq_pointer, .loop_event_pending, .clock_event_pending
);

// ### verification/tb_top.sv
// self-checking bench of the channel status/event bank
// assumes the bank alone; inputs change at the falling edge of ref_clk
`timescale 1ns/1ps
`include "lcse_cfg.svh"
module tb_top;
    logic        ref_clk = 1'b0, reset_n = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, gptr;
    logic [5:0]  pv = 6'h00; // sys up/down, line up/down, ref/src switch
    logic [1:0]  aloop = 2'h0, lost = 2'h0, ps = 2'h0;
    logic        pll = 1'b0, gen = 1'b0, acs = 1'b0, asim = 1'b0, rv = 1'b0, rb = 1'b0;
    logic        berr = 1'b0, pl_on, ln_on, lpc, lp, cp;
    logic [15:0] bec;
    lcse_pkg::lcse_poly_t ord = lcse_pkg::lcse_ord11;
    int          bad_count = 0, n_compared = 0;
    int          runs[4] = '{12, 16, 21, 24};

    // 25 mhz reference clock
    always #20 ref_clk = ~ref_clk;

    lcse_regs DUT (
        .ref_clk, .reset_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
        .sys_loop_up_code(pv[5]), .sys_loop_down_code(pv[4]), .line_loop_up_code(pv[3]),
        .line_loop_down_code(pv[2]), .sys_auto_loop_en(aloop[1]), .line_auto_loop_en(aloop[0]),
        .payload_loop_on(pl_on), .line_loop_on(ln_on), .pll_lock_async(pll),
        .legacy_mode_disable(gen), .masked_event_visible(1'b1), .auto_clock_switch_en(acs),
        .ref_switch_pulse(pv[1]), .src_switch_pulse(pv[0]), .tx_clock_lost_async(lost[1]),
        .alt_ref_clock_lost_async(lost[0]), .pattern_irq_mode(1'b1), .alarm_sim(asim),
        .poly_order(ord), .rx_bit_valid(rv), .rx_bit(rb), .prbs_sync(ps[1]),
        .prbs_inverted(ps[0]), .prbs_bit_error(berr), .loopback_pattern_change_evt(lpc),
        .bit_error_counter(bec), .global_irq_pointer(gptr), .loop_event_pending(lp),
        .clock_event_pending(cp)
    );

    // compare and count, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle strobe; data is registered at the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk({8'h00, reg_rdata & m}, {8'h00, e});
    endtask : rd

    // single-cycle detector pulses
    task automatic pulse(input logic [5:0] p);
        @(negedge ref_clk);
        pv = p;
        @(negedge ref_clk);
        pv = 6'h00;
    endtask : pulse

    // n qualified bits of one value, then the qualifier drops
    task automatic feed(input logic b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            rv = 1'b1;
            rb = b;
        end
        @(negedge ref_clk);
        rv = 1'b0;
    endtask : feed

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // main sequence; every wait is a fixed count, so nothing can hang
    initial begin
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        rd(8'had, 8'hff, 8'h00);
        rd(`LCSE_ADDR_CLK_MASK, 8'hff, 8'hff);
        rd(8'h00, 8'hff, 8'h00);
        aloop = 2'h3;
        pulse(6'h28);
        chk({13'h0, pl_on, ln_on, gptr[6]}, 16'h0007);
        rd(`LCSE_ADDR_LOOP_EVT, 8'hff, 8'h0a);
        rd(`LCSE_ADDR_LOOP_EVT, 8'hff, 8'h00);
        chk({15'h0, lp}, 16'h0000);
        pulse(6'h14);
        chk({14'h0, pl_on, ln_on}, 16'h0000);
        rd(`LCSE_ADDR_LOOP_EVT, 8'hff, 8'h05);
        aloop = 2'h0;
        pulse(6'h28);
        chk({14'h0, pl_on, ln_on}, 16'h0000);
        rd(`LCSE_ADDR_LOOP_EVT, 8'hff, 8'h0a);
        pll = 1'b1;
        repeat (5) @(negedge ref_clk);
        rd(8'had, 8'hff, 8'h03);
        rd(8'had, 8'hff, 8'h02);
        gen = 1'b1;
        rd(8'he7, 8'h01, 8'h01);
        rd(`LCSE_ADDR_CHAN_PTR, 8'h80, 8'h80);
        gen = 1'b0;
        rd(8'he7, 8'h01, 8'h00);
        rd(8'had, 8'hff, 8'h02);
        pll = 1'b0;
        repeat (5) @(negedge ref_clk);
        rd(8'had, 8'hff, 8'h01);
        pulse(6'h03);
        rd(8'hd8, 8'hff, 8'h00);
        acs = 1'b1;
        pulse(6'h03);
        chk({15'h0, cp}, 16'h0000);
        rd(8'hd8, 8'hff, 8'h18);
        rd(8'hd8, 8'hff, 8'h00);
        @(negedge ref_clk);
        reg_addr = `LCSE_ADDR_CLK_MASK;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        pulse(6'h02);
        chk({14'h0, gptr[7], cp}, 16'h0003);
        rd(8'hd8, 8'hff, 8'h10);
        acs = 1'b0;
        lost = 2'h2;
        repeat (5) @(negedge ref_clk);
        rd(8'hfe, 8'h18, 8'h10);
        lost = 2'h1;
        repeat (5) @(negedge ref_clk);
        rd(8'hfe, 8'h18, 8'h08);
        // every order: one bit short, exact length zeros, then ones
        for (int k = 0; k < 4; k++) begin
            ord = lcse_pkg::lcse_poly_t'(k);
            feed(1'b1, 1);
            feed(1'b0, runs[k] - 1);
            rd(8'hda, 8'h07, 8'h00);
            feed(1'b0, 1);
            rd(8'hda, 8'h07, 8'h06);
            feed(1'b1, runs[k]);
            rd(8'hda, 8'h07, 8'h07);
        end
        rd(`LCSE_ADDR_GLOBAL_PTR, 8'h02, 8'h02);
        chk({15'h0, lpc}, 16'h0000);
        feed(1'b0, 1);
        @(negedge ref_clk);
        chk({15'h0, lpc}, 16'h0001);
        ps = 2'h2;
        rd(8'hda, 8'h07, 8'h02);
        ps = 2'h3;
        rd(8'hda, 8'h07, 8'h03);
        asim = 1'b1;
        rd(8'hda, 8'h07, 8'h00);
        asim = 1'b0;
        ps = 2'h2;
        chk(bec, 16'h0000);
        repeat (3) begin
            @(negedge ref_clk);
            berr = 1'b1;
            @(negedge ref_clk);
            berr = 1'b0;
        end
        chk(bec, 16'h0003);
        complete_run();
    end
endmodule : tb_top
